// File: gpib_pkg.sv
// shared constants and carrier types for the instrument-side bus port
// assumes a single system clock; bus lines are active low, open collector
package gpib_pkg;

    localparam int          DATA_W       = 8;
    localparam logic [7:0]  CMD_GRP_MASK = 8'hf0;
    localparam logic [7:0]  ADDR_CMD_LO  = 8'h00;
    localparam logic [7:0]  UNIV_CMD_LO  = 8'h10;
    localparam logic [7:0]  CMD_GTL      = 8'h01;
    localparam logic [7:0]  CMD_LLO      = 8'h11;
    localparam logic [7:0]  CMD_DCL      = 8'h14;
    localparam logic [7:0]  CMD_FAST_CFG_EN = 8'h1f;
    localparam logic [7:0]  ADDR_GRP_MASK = 8'he0;
    localparam logic [7:0]  LISTEN_GRP   = 8'h20;
    localparam logic [7:0]  TALK_GRP     = 8'h40;
    localparam logic [7:0]  FAST_CFG_GRP = 8'h60;
    localparam logic [4:0]  ADDR_FIELD_UNL = 5'h1f;
    localparam logic [4:0]  DEF_PRIMARY_ADDR = 5'h14;

    typedef struct packed {
        logic [7:0] data;
        logic       eoi;
    } bus_byte_t;

    typedef struct packed {
        logic ifc;
        logic atn;
        logic ren;
        logic eoi;
        logic dav;
        logic nrfd;
        logic ndac;
    } ctl_lines_t;

endpackage : gpib_pkg

// File: gpib_skid_buffer.sv
// two-entry buffer between acceptor handshake and the instrument side
// assumes both sides run on i_clk_sys; no combinational path from ready to ready
`timescale 1ns/10ps
`default_nettype none
module gpib_skid_buffer
    import gpib_pkg::*;
#(
    parameter int WIDTH = 9
)(
    input  wire logic             i_clk_sys,
    input  wire logic             i_nrst,
    input  wire logic             i_in_valid,
    input  wire logic [WIDTH-1:0] i_in_data,
    output logic                  o_in_ready,
    output logic                  o_out_valid,
    output logic [WIDTH-1:0]      o_out_data,
    input  wire logic             i_out_ready,
    input  wire logic             i_flush
);
    if (WIDTH < 1)
    begin : g_bad_width
        $error("buffer width must be positive");
    end

    logic [WIDTH-1:0] mem [0:1];
    logic             wr_ptr;
    logic             rd_ptr;
    logic [1:0]       count;
    logic             push;
    logic             pop;

    assign push        = i_in_valid && (count != 2'd2);
    assign pop         = (count != 2'd0) && i_out_ready;
    assign o_in_ready  = (count != 2'd2);
    assign o_out_valid = (count != 2'd0);
    assign o_out_data  = mem[rd_ptr];

    always_ff @(posedge i_clk_sys)
    begin
        if (push) mem[wr_ptr] <= i_in_data;
    end

    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count  <= 2'd0;
        end
        else if (i_flush)
        begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count  <= 2'd0;
        end
        else
        begin
            if (push) wr_ptr <= ~wr_ptr;
            if (pop) rd_ptr <= ~rd_ptr;
            count <= count + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule : gpib_skid_buffer
`default_nettype wire

// File: gpib_instrument_interface.sv
// instrument-side bus port: acceptor handshake, command decode, remote/local state
// assumes bus pins are asynchronous and combined externally as wired-or, active low
//
// Function
// - bytes move one at a time on eight lines, line zero least significant
// - interface clear low returns the bus interface to its default state
// - attention low means interface message, attention high means device message
// - service request pulled low only while the instrument asks for service
// - local to remote change allowed only while remote enable is low
// - end-or-identify low with attention high marks the last byte
// - end-or-identify and attention low together start a parallel poll
// - data valid low only with a valid byte; sample only then
// - acceptor not ready holds not-ready-for-data low; source waits
// - not-data-accepted low while byte is still taken; source waits
// - bus outputs are open collector, only pulling lines low
// - universal commands 10..1f act whether or not addressed
// - addressed commands 00..0f act only when addressed as listener
// - device clear aborts command processing but keeps instrument settings
// - local lockout blocks return to local through front panel keys
// - addressed go-to-local leaves remote for local state
// - fast listener configure commands are ignored
`timescale 1ns/10ps
`default_nettype none
module gpib_instrument_interface
    import gpib_pkg::*;
#(
    parameter logic [4:0] PRIMARY_ADDR = DEF_PRIMARY_ADDR
)(
    input  wire logic              i_clk_sys,
    input  wire logic              i_nrst,
    input  wire logic [DATA_W-1:0] i_dio_n,
    input  wire logic              i_ifc_n,
    input  wire logic              i_atn_n,
    input  wire logic              i_ren_n,
    input  wire logic              i_eoi_n,
    input  wire logic              i_dav_n,
    input  wire logic              i_nrfd_n,
    input  wire logic              i_ndac_n,
    output logic                   o_nrfd_out,
    output logic                   o_nrfd_oe_n,
    output logic                   o_ndac_out,
    output logic                   o_ndac_oe_n,
    output logic                   o_srq_out,
    output logic                   o_srq_oe_n,
    input  wire logic              i_service_req,
    input  wire logic              i_local_key,
    output logic                   o_rx_valid,
    output logic [DATA_W-1:0]      o_rx_data,
    output logic                   o_rx_end,
    input  wire logic              i_rx_ready,
    output logic                   o_remote,
    output logic                   o_lockout,
    output logic                   o_listener,
    output logic                   o_talker,
    output logic                   o_dev_clear,
    output logic                   o_par_poll
);

    // address 31 is the unaddress code, so no device may own it
    if (PRIMARY_ADDR == ADDR_FIELD_UNL)
    begin : g_bad_addr
        $error("primary address must not be the unaddress code");
    end

    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_READY  = 2'b01,
        ST_ACCEPT = 2'b11,
        ST_WAIT   = 2'b10
    } ah_state_t;

    // first stage read only by the second
    logic [DATA_W-1:0] dio_m;
    logic [DATA_W-1:0] dio_s;
    ctl_lines_t        ctl_m;
    ctl_lines_t        ctl_s;
    ctl_lines_t        ctl_raw;
    // front panel key is a pin, so it is synchronised like the bus lines
    logic              key_m;
    logic              key_s;

    ah_state_t         ah_state;
    ah_state_t         next_ah_state;
    logic [7:0]        cmd_byte;
    logic              cmd_strobe;
    logic              dev_strobe;
    logic [7:0]        latched_byte;
    logic              latched_eoi;
    logic              latched_atn;
    logic              take_byte;

    bus_byte_t         buf_in;
    bus_byte_t         buf_out;
    logic              buf_in_ready;
    logic              buf_out_valid;
    logic              dev_clear_pulse;

    assign ctl_raw = '{ifc: i_ifc_n, atn: i_atn_n, ren: i_ren_n, eoi: i_eoi_n,
                       dav: i_dav_n, nrfd: i_nrfd_n, ndac: i_ndac_n};

    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            dio_m <= '1;
            dio_s <= '1;
            ctl_m <= '1;
            ctl_s <= '1;
            key_m <= 1'b0;
            key_s <= 1'b0;
        end
        else
        begin
            dio_m <= i_dio_n;
            dio_s <= dio_m;
            ctl_m <= ctl_raw;
            ctl_s <= ctl_m;
            key_m <= i_local_key;
            key_s <= key_m;
        end
    end

    function automatic logic addr_match(input logic [7:0] b, input logic [7:0] grp,
                                        input logic [4:0] addr);
        addr_match = ((b & ADDR_GRP_MASK) == grp) && (b[4:0] == addr);
    endfunction : addr_match

    function automatic logic is_unaddr(input logic [7:0] b, input logic [7:0] grp);
        is_unaddr = ((b & ADDR_GRP_MASK) == grp) && (b[4:0] == ADDR_FIELD_UNL);
    endfunction : is_unaddr

    function automatic logic in_group(input logic [7:0] b, input logic [7:0] mask,
                                      input logic [7:0] grp);
        in_group = ((b & mask) == grp);
    endfunction : in_group

    // acceptor handshake; device bytes wait for buffer room so no byte is lost
    always_comb
    begin
        next_ah_state = ah_state;
        case (ah_state)
            ST_IDLE:
                if (ctl_s.dav && (!ctl_s.atn || (o_listener && buf_in_ready)))
                    next_ah_state = ST_READY;
            ST_READY:
                if (!ctl_s.dav)
                    next_ah_state = ST_ACCEPT;
                else if (ctl_s.atn && !(o_listener && buf_in_ready))
                    next_ah_state = ST_IDLE;
            ST_ACCEPT:
                next_ah_state = ST_WAIT;
            ST_WAIT:
                if (ctl_s.dav)
                    next_ah_state = ST_IDLE;
            default:
                next_ah_state = ST_IDLE;
        endcase
    end

    assign take_byte = (ah_state == ST_ACCEPT);

    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
            ah_state <= ST_IDLE;
        else if (!ctl_s.ifc)
            ah_state <= ST_IDLE;
        else
            ah_state <= next_ah_state;
    end

    // lines are inverted: a low wire is a true bit
    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            latched_byte <= 8'h00;
            latched_eoi  <= 1'b0;
            latched_atn  <= 1'b0;
        end
        else if (ah_state == ST_READY && !ctl_s.dav)
        begin
            latched_byte <= ~dio_s;
            latched_eoi  <= ~ctl_s.eoi;
            latched_atn  <= ~ctl_s.atn;
        end
    end

    assign cmd_strobe = take_byte && latched_atn;
    assign dev_strobe = take_byte && !latched_atn && o_listener;
    assign cmd_byte   = latched_byte;

    // wire outputs drive only low; release means oe_n high
    // each line is freed only in the one state that means it, and reset frees both,
    // so outside reset a source never sees ready or accepted before this acceptor has earned it
    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            o_nrfd_out  <= 1'b0;
            o_nrfd_oe_n <= 1'b1;
            o_ndac_out  <= 1'b0;
            o_ndac_oe_n <= 1'b1;
        end
        else
        begin
            o_nrfd_out  <= 1'b0;
            o_ndac_out  <= 1'b0;
            o_nrfd_oe_n <= ctl_s.ifc && next_ah_state == ST_READY;
            o_ndac_oe_n <= ctl_s.ifc && next_ah_state == ST_WAIT;
        end
    end

    // service request is its own concern and follows the instrument's request
    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            o_srq_out  <= 1'b0;
            o_srq_oe_n <= 1'b1;
        end
        else
        begin
            o_srq_out  <= 1'b0;
            o_srq_oe_n <= !i_service_req;
        end
    end

    // address state
    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            o_listener <= 1'b0;
            o_talker   <= 1'b0;
        end
        else if (!ctl_s.ifc)
        begin
            o_listener <= 1'b0;
            o_talker   <= 1'b0;
        end
        else if (cmd_strobe)
        begin
            if (addr_match(cmd_byte, LISTEN_GRP, PRIMARY_ADDR))
                o_listener <= 1'b1;
            else if (is_unaddr(cmd_byte, LISTEN_GRP))
                o_listener <= 1'b0;
            if (addr_match(cmd_byte, TALK_GRP, PRIMARY_ADDR))
            begin
                o_talker   <= 1'b1;
                o_listener <= 1'b0;
            end
            else if (in_group(cmd_byte, ADDR_GRP_MASK, TALK_GRP))
                o_talker <= 1'b0;
        end
    end

    // remote, local and lockout; fast configure codes fall through untouched
    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            o_remote  <= 1'b0;
            o_lockout <= 1'b0;
        end
        else if (ctl_s.ren)
        begin
            o_remote  <= 1'b0;
            o_lockout <= 1'b0;
        end
        else if (cmd_strobe && in_group(cmd_byte, CMD_GRP_MASK, UNIV_CMD_LO))
        begin
            if (cmd_byte == CMD_LLO)
                o_lockout <= 1'b1;
        end
        else if (cmd_strobe && in_group(cmd_byte, CMD_GRP_MASK, ADDR_CMD_LO))
        begin
            if (cmd_byte == CMD_GTL && o_listener)
                o_remote <= 1'b0;
        end
        else if (cmd_strobe && addr_match(cmd_byte, LISTEN_GRP, PRIMARY_ADDR))
            o_remote <= 1'b1;
        else if (key_s && !o_lockout)
            o_remote <= 1'b0;
    end

    // fast-mode configure group and its enable are deliberately not decoded
    assign dev_clear_pulse = cmd_strobe && cmd_byte == CMD_DCL;

    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            o_dev_clear <= 1'b0;
            o_par_poll  <= 1'b0;
        end
        else
        begin
            o_dev_clear <= dev_clear_pulse;
            o_par_poll  <= !ctl_s.eoi && !ctl_s.atn && ctl_s.ifc;
        end
    end

    // device bytes; clear only drops queued input, settings lie outside
    assign buf_in = '{data: latched_byte, eoi: latched_eoi};

    gpib_skid_buffer #(
        .WIDTH($bits(bus_byte_t))
    ) u_rx_buffer (
        .i_clk_sys   (i_clk_sys),
        .i_nrst      (i_nrst),
        .i_in_valid  (dev_strobe),
        .i_in_data   (buf_in),
        .o_in_ready  (buf_in_ready),
        .o_out_valid (buf_out_valid),
        .o_out_data  (buf_out),
        .i_out_ready (i_rx_ready && !o_rx_valid),
        .i_flush     (dev_clear_pulse || !ctl_s.ifc)
    );

    // output register so rx ports come straight from flip-flops
    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            o_rx_valid <= 1'b0;
            o_rx_data  <= 8'h00;
            o_rx_end   <= 1'b0;
        end
        else if (o_rx_valid)
        begin
            if (i_rx_ready || dev_clear_pulse)
                o_rx_valid <= 1'b0;
        end
        else if (buf_out_valid && i_rx_ready)
        begin
            o_rx_valid <= 1'b1;
            o_rx_data  <= buf_out.data;
            o_rx_end   <= buf_out.eoi;
        end
    end

endmodule : gpib_instrument_interface
`default_nettype wire

// File: gpib_instrument_interface_sva.sv
// assertions on the instrument-side bus port, bound to its top module
// sees only top-level ports; bus inputs are raw wire levels, active low
`timescale 1ns/10ps
`default_nettype none
module gpib_instrument_interface_sva
(
    input wire logic       i_clk_sys,
    input wire logic       i_nrst,
    input wire logic [7:0] i_dio_n,
    input wire logic       i_ifc_n,
    input wire logic       i_atn_n,
    input wire logic       i_ren_n,
    input wire logic       i_eoi_n,
    input wire logic       i_dav_n,
    input wire logic       i_service_req,
    input wire logic       i_rx_ready,
    input wire logic       o_nrfd_out,
    input wire logic       o_nrfd_oe_n,
    input wire logic       o_ndac_out,
    input wire logic       o_ndac_oe_n,
    input wire logic       o_srq_out,
    input wire logic       o_srq_oe_n,
    input wire logic       o_rx_valid,
    input wire logic [7:0] o_rx_data,
    input wire logic       o_remote,
    input wire logic       o_lockout,
    input wire logic       o_listener,
    input wire logic       o_talker,
    input wire logic       o_dev_clear,
    input wire logic       o_par_poll
);
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_nrst);

    chk_drive_zero: assert property (!o_nrfd_out && !o_ndac_out && !o_srq_out)
        else $error("bus drive value not low");
    chk_srq_pull: assert property (i_service_req [*5] |-> !o_srq_oe_n)
        else $error("service request not pulled");
    chk_accept_order: assert property ($rose(o_ndac_oe_n) |-> !$past(i_dav_n, 2) && !o_nrfd_oe_n)
        else $error("accepted released without valid byte");
    chk_ready_cause: assert property ($rose(o_nrfd_oe_n) |-> $past(i_dav_n, 2))
        else $error("ready released while valid low");
    chk_ifc_clear: assert property (!i_ifc_n [*5] |-> !o_nrfd_oe_n && !o_listener && !o_talker)
        else $error("interface clear not honoured");
    chk_dcl_cause: assert property (o_dev_clear |-> !$past(i_atn_n, 3) && $past(i_dio_n, 3) == 8'heb ##1 !o_dev_clear)
        else $error("device clear pulse without command");
    chk_poll_on: assert property ((!i_atn_n && !i_eoi_n) [*5] |-> o_par_poll)
        else $error("parallel poll not flagged");
    chk_ren_drop: assert property (i_ren_n [*5] |-> !o_remote && !o_lockout)
        else $error("remote held without enable");
    chk_remote_cause: assert property ($rose(o_remote) |-> !$past(i_ren_n, 3))
        else $error("remote entered without enable");
    chk_rx_hold: assert property (o_rx_valid && !i_rx_ready |=> o_rx_valid && $stable(o_rx_data))
        else $error("stalled byte lost");
endmodule : gpib_instrument_interface_sva

bind gpib_instrument_interface gpib_instrument_interface_sva u_sva
(
    .i_clk_sys, .i_nrst, .i_dio_n, .i_ifc_n, .i_atn_n, .i_ren_n, .i_eoi_n, .i_dav_n,
    .i_service_req, .i_rx_ready, .o_nrfd_out, .o_nrfd_oe_n, .o_ndac_out, .o_ndac_oe_n,
    .o_srq_out, .o_srq_oe_n, .o_rx_valid, .o_rx_data, .o_remote, .o_lockout,
    .o_listener, .o_talker, .o_dev_clear, .o_par_poll
);
`default_nettype wire

// File: gpib_ctrl_model.sv
// bus controller model: sources bytes over the three-wire handshake
// assumes acceptor lines arrive as resolved wire levels with pull-ups
`timescale 1ns/10ps
`default_nettype none
module gpib_ctrl_model
(
    input  wire logic  i_clk_sys,
    input  wire logic  i_nrfd_n,
    input  wire logic  i_ndac_n,
    output logic [7:0] o_dio_n,
    output logic       o_atn_n,
    output logic       o_eoi_n,
    output logic       o_dav_n
);
    initial
    begin
        o_dio_n = 8'hff;
        o_atn_n = 1'b1;
        o_eoi_n = 1'b1;
        o_dav_n = 1'b1;
    end

    // atn and eoi are wire levels; waits are bounded so a dead acceptor cannot hang
    task automatic send(input logic [7:0] b, input logic atn, input logic eoi, input int slow);
        int n;
        // one spare edge keeps the previous call's release apart from this setup
        repeat (slow + 1) @(posedge i_clk_sys);
        o_dio_n <= ~b;
        o_atn_n <= atn;
        o_eoi_n <= eoi;
        // the acceptor needs four edges to see a new attention level and answer on nrfd
        repeat (4) @(posedge i_clk_sys);
        for (n = 0; n < 400 && !i_nrfd_n; n++) @(posedge i_clk_sys);
        o_dav_n <= 1'b0;
        for (n = 0; n < 400 && !i_ndac_n; n++) @(posedge i_clk_sys);
        o_dav_n <= 1'b1;
        @(posedge i_clk_sys);
        // released lines return to the pull-up level
        o_dio_n <= 8'hff;
        o_eoi_n <= 1'b1;
    endtask : send

    task automatic poll(input logic on);
        o_atn_n <= !on;
        o_eoi_n <= !on;
    endtask : poll
endmodule : gpib_ctrl_model
`default_nettype wire

// File: gpib_instrument_interface_tb.sv
// self-checking bench for the instrument-side bus port
// a controller model sources bytes; a queue predicts the byte stream and shadow variables predict the state
`timescale 1ns/10ps
`default_nettype none
module gpib_instrument_interface_tb;
    import gpib_pkg::*;
    localparam logic [4:0] PA = 5'h0b;
    logic       i_clk_sys, i_nrst, i_ifc_n, i_ren_n, i_service_req, i_local_key, i_rx_ready;
    logic [7:0] i_dio_n, o_rx_data;
    logic       i_atn_n, i_eoi_n, i_dav_n, o_rx_valid, o_rx_end, o_remote, o_lockout;
    logic       o_nrfd_out, o_nrfd_oe_n, o_ndac_out, o_ndac_oe_n, o_srq_out, o_srq_oe_n;
    logic       o_listener, o_talker, o_dev_clear, o_par_poll, stall;
    wire logic  i_nrfd_n = o_nrfd_oe_n | o_nrfd_out;
    wire logic  i_ndac_n = o_ndac_oe_n | o_ndac_out;
    int         errors, tests_run, cyc, rem, lsn, tlk, llo, dcl, seen;
    int         exp_q[$];

    gpib_instrument_interface #(.PRIMARY_ADDR(PA)) dut
    (
        .i_clk_sys, .i_nrst, .i_dio_n, .i_ifc_n, .i_atn_n, .i_ren_n, .i_eoi_n, .i_dav_n,
        .i_nrfd_n, .i_ndac_n, .o_nrfd_out, .o_nrfd_oe_n, .o_ndac_out, .o_ndac_oe_n,
        .o_srq_out, .o_srq_oe_n, .i_service_req, .i_local_key, .o_rx_valid, .o_rx_data,
        .o_rx_end, .i_rx_ready, .o_remote, .o_lockout, .o_listener, .o_talker,
        .o_dev_clear, .o_par_poll
    );
    gpib_ctrl_model ctl
    (
        .i_clk_sys, .i_nrfd_n, .i_ndac_n,
        .o_dio_n(i_dio_n), .o_atn_n(i_atn_n), .o_eoi_n(i_eoi_n), .o_dav_n(i_dav_n)
    );

    initial
    begin
        i_clk_sys = 1'b0;
        forever #50 i_clk_sys = ~i_clk_sys;
    end

    task automatic close_out;
        if (errors == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : close_out

    task automatic chk(input string n, input int e, input logic [8:0] g);
        tests_run++;
        if (g !== 9'(e))
        begin
            errors++;
            $display("ERROR %s expected %h seen %h", n, 9'(e), g);
        end
    endtask : chk

    // consumer stalls at random so the two-entry buffer sees back-pressure
    always @(posedge i_clk_sys)
    begin
        i_rx_ready <= !stall && ($urandom % 3 != 0);
        if (o_dev_clear === 1'b1) seen++;
        if (o_rx_valid === 1'b1 && i_rx_ready === 1'b1)
            chk("rx", exp_q.pop_front(), {o_rx_end, o_rx_data});
        cyc++;
        if (cyc == 6000)
        begin
            errors++;
            close_out;
        end
    end

    task automatic wait_chk(input int n);
        repeat (n) @(posedge i_clk_sys);
        chk("remote", rem, o_remote);
        chk("lockout", llo, o_lockout);
        chk("listener", lsn, o_listener);
        chk("talker", tlk, o_talker);
        chk("dev_clear", dcl, 9'(seen));
    endtask : wait_chk

    task automatic burst(input int cnt);
        logic [7:0] b;
        logic       e;
        for (int i = 0; i < cnt; i++)
        begin
            b = (i == 3) ? 8'h14 : 8'($urandom);
            e = (i == cnt - 1) || ($urandom % 4 == 0);
            exp_q.push_back({e, b});
            ctl.send(b, 1'b1, !e, $urandom % 3);
        end
    endtask : burst

    task automatic cmd(input logic [7:0] c);
        ctl.send(c, 1'b0, 1'b1, $urandom % 3);
        if (c == {3'b001, PA}) lsn = 1;
        if (c == {3'b001, PA} && !i_ren_n) rem = 1;
        if (c == 8'h3f) lsn = 0;
        if (c[7:5] == 3'b010) tlk = (c[4:0] == PA);
        if (c == {3'b010, PA}) lsn = 0;
        if (c == 8'h11) llo = 1;
        if (c == 8'h01 && lsn != 0) rem = 0;
        if (c == 8'h14) dcl++;
        wait_chk(4);
    endtask : cmd

    initial
    begin
        void'($urandom(62483));
        {i_nrst, i_service_req, i_local_key, i_rx_ready, stall, i_ren_n} = '0;
        i_ifc_n = 1'b1;
        {errors, tests_run, cyc, rem, lsn, tlk, llo, dcl, seen} = '0;
        repeat (10) @(posedge i_clk_sys);
        chk("nrfd_rst", 1, o_nrfd_oe_n);
        i_nrst <= 1'b1;
        wait_chk(4);
        cmd({3'b001, PA});
        burst(12);
        stall <= 1'b1;
        fork
            burst(4);
        join_none
        repeat (80) @(posedge i_clk_sys);
        chk("nrfd_full", 0, o_nrfd_oe_n);
        stall <= 1'b0;
        wait fork;
        for (int n = 0; n < 200 && exp_q.size() > 0; n++) @(posedge i_clk_sys);
        cmd(8'h11);
        i_local_key <= 1'b1;
        wait_chk(8);
        i_local_key <= 1'b0;
        cmd(8'h1f);
        cmd(8'h60);
        cmd(8'h14);
        cmd(8'h01);
        cmd({3'b001, PA});
        cmd(8'h3f);
        cmd(8'h01);
        cmd({3'b010, PA});
        cmd({3'b010, ~PA});
        i_ren_n <= 1'b1;
        rem = 0;
        llo = 0;
        wait_chk(8);
        i_ren_n <= 1'b0;
        cmd({3'b001, PA});
        i_local_key <= 1'b1;
        rem = 0;
        wait_chk(8);
        i_local_key <= 1'b0;
        i_service_req <= 1'b1;
        repeat (8) @(posedge i_clk_sys);
        chk("srq", 0, o_srq_oe_n);
        i_service_req <= 1'b0;
        ctl.poll(1'b1);
        repeat (8) @(posedge i_clk_sys);
        chk("srq", 1, o_srq_oe_n);
        chk("poll", 1, o_par_poll);
        ctl.poll(1'b0);
        repeat (8) @(posedge i_clk_sys);
        chk("poll", 0, o_par_poll);
        i_ifc_n <= 1'b0;
        lsn = 0;
        tlk = 0;
        wait_chk(8);
        chk("nrfd_ifc", 0, o_nrfd_oe_n);
        i_ifc_n <= 1'b1;
        repeat (4) @(posedge i_clk_sys);
        close_out;
    end
endmodule : gpib_instrument_interface_tb
`default_nettype wire
